//--- design/fifo_pkg.sv
package fifo_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] ctrl_off      = 12'h000;
	localparam logic [11:0] ab_ae_off     = 12'h004;
	localparam logic [11:0] ab_af_off     = 12'h008;
	localparam logic [11:0] ba_ae_off     = 12'h00c;
	localparam logic [11:0] ba_af_off     = 12'h010;
	localparam logic [11:0] status_off    = 12'h014;
	localparam logic [11:0] wdata_off     = 12'h018;
	localparam logic [11:0] rdata_off     = 12'h01c;
	localparam logic [11:0] irq_stat_off  = 12'h020;
	localparam logic [11:0] irq_mask_off  = 12'h024;
	localparam logic [11:0] bypass_off    = 12'h028;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int          sel_pos        = 0;
	localparam int          sel_w          = 3;
	localparam int          bypass_pos     = 3;
	localparam int          enable_n_pos   = 4;
	localparam int          oe_n_pos       = 5;
	localparam int          dir_pos        = 6;
	localparam logic [8:0]  offset_rst     = 9'h008;
	localparam logic [2:0]  sel_fifo       = 3'h0;
	localparam logic [2:0]  sel_bypass     = 3'h1;
	localparam int          data_w         = 18;
	localparam int          depth_small    = 256;
	localparam int          depth_large    = 512;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          clk_period_ps       = 8000;
	localparam int          first_read_latency_ps = 16000;
	localparam int          first_read_cycles   =
		(first_read_latency_ps + clk_period_ps - 1) / clk_period_ps;

	typedef enum logic [1:0]
	{
		byp_idle  = 2'b00,
		byp_live  = 2'b01,
		byp_grace = 2'b10,
		byp_done  = 2'b11
	} bypass_state_t;

endpackage

//--- design/fifo_flags.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// flag generator for one direction
// ------------------------------------------------------------
module fifo_flags
#(
	parameter int depth = 512,
	parameter int aw    = 10
)
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic [aw-1:0] count,
	input  wire logic [8:0]    ae_offset,
	input  wire logic [8:0]    af_offset,
	output logic               empty_flag_n,
	output logic               almost_empty_flag_n,
	output logic               almost_full_flag_n,
	output logic               full_flag_n
);

	logic [aw-1:0] ae_lim;
	logic [aw-1:0] af_lim;

	assign ae_lim = aw'(ae_offset);
	assign af_lim = aw'(depth) - aw'(af_offset);

	// flags registered, active low
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			empty_flag_n        <= 1'b0;
			almost_empty_flag_n <= 1'b0;
			almost_full_flag_n  <= 1'b1;
			full_flag_n         <= 1'b1;
		end
		else
		begin
			empty_flag_n        <= (count != '0);
			almost_empty_flag_n <= (count > ae_lim);
			almost_full_flag_n  <= (count < af_lim);
			full_flag_n         <= (count != aw'(depth));
		end
	end

endmodule

//--- design/bififo_port_b.sv
`timescale 1ns/10ps
// How it works
// - enabled port b read loads output register
// - disabled read holds register and pointer
// - select 000 or 1xx reads fifo word
// - select 001 reads bypass word instead
// - depth 256 or 512 sets full level
// - thresholds come from per-direction offset registers
// - first word appears within latency window
// - port a deselect ends bypass after one grace cycle
// - bypass indicator rise clears bypass flags
// - one cycle grace to read bypass word
// - almost-empty flag updates on reader clock
// - almost-full flag updates on writer clock
// - almost-empty assert means n words or fewer
// - almost-full assert means full minus m words or more
// - all offsets reset to eight
// - empty and full use fixed levels
module bififo_port_b
#(
	parameter int depth = fifo_pkg::depth_large,
	parameter int aw    = $clog2(depth) + 1
)
(
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	output logic                             irq,
	output logic      [fifo_pkg::data_w-1:0] port_b_data_out,
	output logic                             port_b_data_oe_n,
	output logic                             ab_almost_empty_flag,
	output logic                             ab_almost_full_flag,
	output logic                             ab_empty_flag,
	output logic                             ab_full_flag
);
	localparam int dw = fifo_pkg::data_w;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [dw-1:0] mem [depth];
	logic [aw-2:0] wr_ptr_q;
	logic [aw-2:0] rd_ptr_q;
	logic [aw-1:0] count_q;
	logic [dw-1:0] out_q;
	logic [dw-1:0] bypass_word_q;
	logic [8:0]    ab_ae_q;
	logic [8:0]    ab_af_q;
	logic [8:0]    ba_ae_q;
	logic [8:0]    ba_af_q;
	logic [2:0]    port_a_resource_select;
	logic          port_a_select_n;
	logic          port_b_bypass_indicator;
	logic          port_b_enable_n;
	logic          port_b_output_enable_n;
	logic          port_b_direction;
	logic          bypass_ind_prev_q;
	logic [3:0]    irq_stat_q;
	logic [3:0]    irq_mask_q;
	logic [3:0]    events;
	fifo_pkg::bypass_state_t byp_q;

	// ------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ------------------------------------------------------------
	logic        ap_wr_q;
	logic        ap_rd_q;
	logic [11:0] ap_addr_q;
	logic        bus_wr;
	logic        push;
	logic        pop;
	logic        read_en;
	logic        bypass_sel;
	logic        full;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_q   <= 1'b0;
			ap_rd_q   <= 1'b0;
			ap_addr_q <= 12'h000;
		end
		else if (hready)
		begin
			ap_wr_q   <= hsel && htrans[1] && hwrite;
			ap_rd_q   <= hsel && htrans[1] && !hwrite;
			ap_addr_q <= haddr[11:0];
		end
	end
	assign bus_wr = ap_wr_q;
	assign full   = (count_q == aw'(depth));

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			port_a_resource_select  <= fifo_pkg::sel_fifo;
			port_a_select_n         <= 1'b1;
			port_b_enable_n         <= 1'b1;
			port_b_output_enable_n  <= 1'b1;
			port_b_direction        <= 1'b1;
		end
		else if (bus_wr && ap_addr_q == fifo_pkg::ctrl_off)
		begin
			port_a_resource_select  <= hwdata[fifo_pkg::sel_pos +:
				fifo_pkg::sel_w];
			port_a_select_n         <= hwdata[fifo_pkg::bypass_pos];
			port_b_enable_n         <= hwdata[fifo_pkg::enable_n_pos];
			port_b_output_enable_n  <= hwdata[fifo_pkg::oe_n_pos];
			port_b_direction        <= hwdata[fifo_pkg::dir_pos];
		end
	end

	// separate bypass indicator register so a rise is a clean event
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			port_b_bypass_indicator <= 1'b0;
		else if (bus_wr && ap_addr_q == fifo_pkg::bypass_off)
			port_b_bypass_indicator <= hwdata[0];
	end

	// ------------------------------------------------------------
	// offset registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ab_ae_q <= fifo_pkg::offset_rst;
			ab_af_q <= fifo_pkg::offset_rst;
			ba_ae_q <= fifo_pkg::offset_rst;
			ba_af_q <= fifo_pkg::offset_rst;
		end
		else if (bus_wr)
		begin
			// small depth still stores and compares bit 8, which software should leave zero
			if (ap_addr_q == fifo_pkg::ab_ae_off)
				ab_ae_q <= hwdata[8:0];
			else if (ap_addr_q == fifo_pkg::ab_af_off)
				ab_af_q <= hwdata[8:0];
			else if (ap_addr_q == fifo_pkg::ba_ae_off)
				ba_ae_q <= hwdata[8:0];
			else if (ap_addr_q == fifo_pkg::ba_af_off)
				ba_af_q <= hwdata[8:0];
		end
	end

	// ------------------------------------------------------------
	// bypass sequencing
	// ------------------------------------------------------------
	assign bypass_sel = (port_a_resource_select == fifo_pkg::sel_bypass)
		&& (byp_q == fifo_pkg::byp_live || byp_q == fifo_pkg::byp_grace);
	assign read_en = port_b_direction && !port_b_enable_n;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bypass_ind_prev_q <= 1'b0;
		else
			bypass_ind_prev_q <= port_b_bypass_indicator;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			byp_q <= fifo_pkg::byp_idle;
		else if (port_b_bypass_indicator && !bypass_ind_prev_q)
			byp_q <= fifo_pkg::byp_idle;
		else
		begin
			case (byp_q)
				fifo_pkg::byp_idle:
					if (!port_a_select_n &&
						port_a_resource_select == fifo_pkg::sel_bypass)
						byp_q <= fifo_pkg::byp_live;
				fifo_pkg::byp_live:
					if (port_a_select_n)
						byp_q <= fifo_pkg::byp_grace;
				fifo_pkg::byp_grace:
					byp_q <= fifo_pkg::byp_done;
				default:
					byp_q <= fifo_pkg::byp_done;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bypass_word_q <= '0;
		else if (bus_wr && ap_addr_q == fifo_pkg::wdata_off &&
			port_a_resource_select == fifo_pkg::sel_bypass)
			bypass_word_q <= hwdata[dw-1:0];
	end

	// ------------------------------------------------------------
	// fifo array and read path
	// ------------------------------------------------------------
	assign push = bus_wr && ap_addr_q == fifo_pkg::wdata_off &&
		port_a_resource_select != fifo_pkg::sel_bypass && !full;
	// write and read on the same edge: word visible one edge later
	assign pop = read_en && !bypass_sel && count_q != '0;
	always_ff @(posedge hclk)
	begin
		if (push)
			mem[wr_ptr_q] <= hwdata[dw-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == (aw-1)'(depth - 1)) ?
					'0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == (aw-1)'(depth - 1)) ?
					'0 : rd_ptr_q + 1'b1;
			count_q <= count_q + aw'(push) - aw'(pop);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			out_q <= '0;
		else if (read_en && bypass_sel)
			out_q <= bypass_word_q;
		else if (pop)
			out_q <= mem[rd_ptr_q];
	end
	assign port_b_data_out  = out_q;
	assign port_b_data_oe_n = !(port_b_direction &&
		!port_b_output_enable_n);

	// ------------------------------------------------------------
	// flags
	// ------------------------------------------------------------
	fifo_flags
	#(
		.depth (depth),
		.aw    (aw)
	)
	u_ab_flags
	(
		.hclk                (hclk),
		.hresetn             (hresetn),
		.count               (count_q),
		.ae_offset           (ab_ae_q),
		.af_offset           (ab_af_q),
		.empty_flag_n        (ab_empty_flag),
		.almost_empty_flag_n (ab_almost_empty_flag),
		.almost_full_flag_n  (ab_almost_full_flag),
		.full_flag_n         (ab_full_flag)
	);

	// ------------------------------------------------------------
	// interrupts: set wins over write-one-to-clear
	// ------------------------------------------------------------
	assign events = {!ab_full_flag, !ab_almost_full_flag,
		!ab_almost_empty_flag, byp_q == fifo_pkg::byp_grace};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_stat_q <= 4'h0;
			irq_mask_q <= 4'h0;
		end
		else
		begin
			if (bus_wr && ap_addr_q == fifo_pkg::irq_stat_off)
				irq_stat_q <= (irq_stat_q & ~hwdata[3:0]) | events;
			else
				irq_stat_q <= irq_stat_q | events;
			if (bus_wr && ap_addr_q == fifo_pkg::irq_mask_off)
				irq_mask_q <= hwdata[3:0];
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// read data, combinational in the data phase
	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (ap_rd_q)
		begin
			if (ap_addr_q == fifo_pkg::ctrl_off)
				hrdata[6:0] = {port_b_direction, port_b_output_enable_n,
					port_b_enable_n, port_a_select_n,
					port_a_resource_select};
			else if (ap_addr_q == fifo_pkg::ab_ae_off)
				hrdata[8:0] = ab_ae_q;
			else if (ap_addr_q == fifo_pkg::ab_af_off)
				hrdata[8:0] = ab_af_q;
			else if (ap_addr_q == fifo_pkg::ba_ae_off)
				hrdata[8:0] = ba_ae_q;
			else if (ap_addr_q == fifo_pkg::ba_af_off)
				hrdata[8:0] = ba_af_q;
			else if (ap_addr_q == fifo_pkg::status_off)
				hrdata[15:0] = {byp_q, ab_full_flag, ab_almost_full_flag,
					ab_almost_empty_flag, ab_empty_flag,
					10'(count_q)};
			else if (ap_addr_q == fifo_pkg::rdata_off)
				hrdata[dw-1:0] = out_q;
			else if (ap_addr_q == fifo_pkg::irq_stat_off)
				hrdata[3:0] = irq_stat_q;
			else if (ap_addr_q == fifo_pkg::irq_mask_off)
				hrdata[3:0] = irq_mask_q;
			else if (ap_addr_q == fifo_pkg::bypass_off)
				hrdata[0] = port_b_bypass_indicator;
		end
	end

endmodule

//--- verification/port_b_sva.sv
`timescale 1ns/10ps
module port_b_sva
(
	input wire logic                        hclk,
	input wire logic                        hresetn,
	input wire logic                        hsel,
	input wire logic [31:0]                 haddr,
	input wire logic [1:0]                  htrans,
	input wire logic                        hwrite,
	input wire logic                        hready,
	input wire logic [31:0]                 hrdata,
	input wire logic                        hreadyout,
	input wire logic                        hresp,
	input wire logic [fifo_pkg::data_w-1:0] port_b_data_out,
	input wire logic                        ab_almost_empty_flag,
	input wire logic                        ab_almost_full_flag,
	input wire logic                        ab_empty_flag,
	input wire logic                        ab_full_flag
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic        rd_q;
	logic [11:0] ra_q;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			rd_q <= 1'b0;
		else
			rd_q <= hsel && htrans[1] && hready && !hwrite;

	always_ff @(posedge hclk)
		ra_q <= haddr[11:0];

	// ------------------------------------------------------------
	// bus and flags
	// ------------------------------------------------------------
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	ready_high_a: assert property (hreadyout == 1'b1)
		else $error("wait state seen");
	unmapped_zero_a: assert property (rd_q && ra_q > fifo_pkg::bypass_off
		|-> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
	out_read_a: assert property (
		rd_q && ra_q == fifo_pkg::rdata_off
		|-> hrdata[17:0] == port_b_data_out) else $error("output mismatch");
	empty_ae_a: assert property (
		!ab_empty_flag |-> !ab_almost_empty_flag) else $error("empty w/o ae");
	full_af_a: assert property (
		!ab_full_flag |-> !ab_almost_full_flag) else $error("full w/o af");
	rst_flags_a: assert property ($rose(hresetn)
		|-> !ab_empty_flag && ab_full_flag && ab_almost_full_flag)
		else $error("flags wrong after reset");
	leave_empty_a: assert property (
		$rose(ab_empty_flag) |-> ab_full_flag) else $error("empty to full");

	cover property ($fell(ab_full_flag));
	cover property ($rose(ab_almost_empty_flag));
	cover property (rd_q && ra_q == fifo_pkg::rdata_off);
endmodule

//--- verification/port_b_sink.sv
`timescale 1ns/10ps
module port_b_sink
(
	input wire logic                        hclk,
	input wire logic                        hresetn,
	input wire logic [fifo_pkg::data_w-1:0] data,
	input wire logic                        oe_n
);
	logic [17:0] got[$];
	logic [17:0] last_q = 18'h3_ffff;

	// looks every cycle: a pending bypass word lasts one cycle
	// tracks the bus while disabled too, so a stale word is not new
	// limitation: two equal words in a row count as one
	always @(posedge hclk)
		if (hresetn)
		begin
			if (!oe_n && data !== last_q)
				got.push_back(data);
			last_q = data;
		end
endmodule

//--- verification/bififo_port_b_read_bypass_flags_tb.sv
`timescale 1ns/10ps
module bififo_port_b_read_bypass_flags_tb;
	logic        hclk, hresetn, hsel, hwrite, hready;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, irq, oe_n, ae, af, ef, ff;
	logic [17:0] dout;
	int          bad_count, total_checks;

	assign hready = hreadyout;

	bififo_port_b #(.depth(256)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.port_b_data_out(dout), .port_b_data_oe_n(oe_n),
		.ab_almost_empty_flag(ae), .ab_almost_full_flag(af),
		.ab_empty_flag(ef), .ab_full_flag(ff));

	port_b_sink sink (.hclk(hclk), .hresetn(hresetn), .data(dout),
		.oe_n(oe_n));

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task conclude;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task check_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t flag %b exp %b", $time, got, exp);
		end
	endtask

	// ------------------------------------------------------------
	// bus master
	// ------------------------------------------------------------
	task wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 100)
			begin
				$display("[FAIL] %0t bus wait timeout", $time);
				bad_count++;
				conclude;
			end
			@(posedge hclk);
		end
	endtask

	task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0000_0000);
		check_word(rd, exp);
	endtask

	// no fixed drain time: bounded wait for the empty flag
	task wait_empty;
		int n;
		n = 0;
		while (ef !== 1'b0)
		begin
			n++;
			if (n > 600)
			begin
				$display("[FAIL] %0t drain wait timeout", $time);
				bad_count++;
				conclude;
			end
			@(posedge hclk);
		end
		repeat (3) @(posedge hclk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task test_reset;
		check_flag(ef, 1'b0);
		check_flag(ff, 1'b1);
		rdc(fifo_pkg::ab_ae_off, 32'h0000_0008);
		rdc(fifo_pkg::ab_af_off, 32'h0000_0008);
		rdc(fifo_pkg::ba_ae_off, 32'h0000_0008);
		rdc(fifo_pkg::ba_af_off, 32'h0000_0008);
		rdc(fifo_pkg::ctrl_off, 32'h0000_0078);
		rdc(12'h030, 32'h0000_0000);
		$display("test reset done");
	endtask

	task test_flags;
		wr(fifo_pkg::ab_af_off, 32'h0000_00fa);
		for (int i = 1; i <= 8; i++)
			wr(fifo_pkg::wdata_off, i);
		repeat (3) @(posedge hclk);
		check_flag(ae, 1'b0);
		check_flag(af, 1'b0);
		rdc(fifo_pkg::status_off, 32'h0000_2408);
		wr(fifo_pkg::wdata_off, 32'h0000_0009);
		repeat (3) @(posedge hclk);
		check_flag(ae, 1'b1);
		check_word({14'h0000, dout}, 32'h0000_0000);
		$display("test flags done");
	endtask

	task test_drain;
		wr(fifo_pkg::ctrl_off, 32'h0000_004c);
		wait_empty;
		check_word(sink.got.size(), 32'h0000_0009);
		for (int i = 0; i < 9; i++)
			check_word({14'h0000, sink.got[i]}, i + 1);
		check_flag(oe_n, 1'b0);
		wr(fifo_pkg::ctrl_off, 32'h0000_0078);
		repeat (2) @(posedge hclk);
		check_flag(oe_n, 1'b1);
		$display("test drain done");
	endtask

	task test_full;
		sink.got.delete();
		wr(fifo_pkg::irq_stat_off, 32'h0000_000f);
		wr(fifo_pkg::ctrl_off, 32'h0000_0058);
		for (int i = 0; i <= 256; i++)
			wr(fifo_pkg::wdata_off, 32'h0000_0100 + i);
		repeat (3) @(posedge hclk);
		check_flag(ff, 1'b0);
		check_flag(irq, 1'b0);
		wr(fifo_pkg::irq_mask_off, 32'h0000_0008);
		@(posedge hclk);
		check_flag(irq, 1'b1);
		wr(fifo_pkg::ctrl_off, 32'h0000_0048);
		wait_empty;
		check_word(sink.got.size(), 32'h0000_0100);
		check_word({14'h0000, sink.got[255]}, 32'h0000_01ff);
		wr(fifo_pkg::irq_stat_off, 32'h0000_0008);
		@(posedge hclk);
		check_flag(irq, 1'b0);
		$display("test full done");
	endtask

	task test_bypass;
		wr(fifo_pkg::ctrl_off, 32'h0000_0041);
		wr(fifo_pkg::wdata_off, 32'h0002_1234);
		repeat (3) @(posedge hclk);
		rdc(fifo_pkg::rdata_off, 32'h0002_1234);
		check_word({14'h0000, sink.got[$]}, 32'h0002_1234);
		xfer(fifo_pkg::status_off, 1'b0, 32'h0000_0000);
		check_word({22'h00_0000, rd[9:0]}, 32'h0000_0000);
		wr(fifo_pkg::ctrl_off, 32'h0000_0049);
		repeat (4) @(posedge hclk);
		xfer(fifo_pkg::status_off, 1'b0, 32'h0000_0000);
		check_word({30'h0000_0000, rd[15:14]}, fifo_pkg::byp_done);
		wr(fifo_pkg::bypass_off, 32'h0000_0000);
		wr(fifo_pkg::bypass_off, 32'h0000_0001);
		repeat (2) @(posedge hclk);
		xfer(fifo_pkg::status_off, 1'b0, 32'h0000_0000);
		check_word({30'h0000_0000, rd[15:14]}, fifo_pkg::byp_idle);
		$display("test bypass done");
	endtask

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		bad_count = 0;
		total_checks = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_reset;
		test_flags;
		test_drain;
		test_full;
		test_bypass;
		conclude;
	end
endmodule

bind bififo_port_b port_b_sva chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .port_b_data_out(port_b_data_out),
	.ab_almost_empty_flag(ab_almost_empty_flag),
	.ab_almost_full_flag(ab_almost_full_flag),
	.ab_empty_flag(ab_empty_flag), .ab_full_flag(ab_full_flag));
